// [core/sac_core.sv]
// control, status and result registers of the 10-bit successive approximation converter
`timescale 1ns/1ps

module sac_core
	import sac_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	input  wire sac_pkg::sac_av_req_t av_req,
	output logic                      avs_waitrequest,
	output logic [31:0]               avs_readdata,
	input  wire logic                 low_power_entry,
	input  wire logic [9:0]           analog_value,
	output logic [7:0]                channel_enable,
	output logic                      sample_active,
	output logic                      conversion_done_interrupt
);
	import sac_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// true when the address equals the byte address of a register index
	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
		hit = (addr == {idx, 2'b00});
	endfunction

	// conversion length for a time code; reserved codes take the longest
	function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] code);
		unique case (code)
			3'h0:    conv_cycles = CONV_CYC_0;
			3'h1:    conv_cycles = CONV_CYC_1;
			3'h2:    conv_cycles = CONV_CYC_2;
			3'h3:    conv_cycles = CONV_CYC_3;
			3'h4:    conv_cycles = CONV_CYC_4;
			default: conv_cycles = CONV_CYC_5;
		endcase
	endfunction

	// one-hot input enable from gate and channel code
	function automatic logic [7:0] chan_onehot(input logic gate, input logic [3:0] chan);
		chan_onehot = 8'h00;
		if (gate && !chan[3]) begin
			chan_onehot = 8'h01 << chan[2:0];
		end
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	sac_state_t q;
	sac_state_t d;

	logic       accept;
	logic       commit;
	logic       rd_accept;
	logic       wr_commit;
	logic       wr_lane0;
	logic [7:0] wd;
	logic [7:0] rmux;
	logic       mode_runs;

	// bus phases: accept samples the request, commit is the acknowledged edge
	assign accept    = (av_req.read || av_req.write) && q.waitreq;
	assign commit    = (av_req.read || av_req.write) && !q.waitreq;
	assign rd_accept = accept && av_req.read;
	assign wr_lane0  = av_req.byteenable[0];
	assign wr_commit = commit && av_req.write && wr_lane0;
	assign wd        = av_req.writedata[7:0];
	assign mode_runs = (q.mode == MODE_SINGLE) || (q.mode == MODE_REPEAT);

	// ------------------------------------------------------------
	// read data mux
	// ------------------------------------------------------------

	// status bits 5..3 are wired to zero, so written junk never shows
	always_comb begin
		rmux = 8'h00;
		if (hit(av_req.address, IDX_CONTROL)) begin
			rmux = {q.start, q.mode, q.gate, q.chan};
		end else if (hit(av_req.address, IDX_STATUS)) begin
			rmux = {q.done, q.busy, 3'b000, q.ctime};
		end else if (hit(av_req.address, IDX_RESULT_LOW)) begin
			rmux = q.result[7:0];
		end else if (hit(av_req.address, IDX_RESULT_HIGH)) begin
			rmux = {6'b000000, q.result[9:8]};
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------

	// later sections override earlier ones: read clear, engine, start, write, power
	always_comb begin
		d     = q;
		d.irq = 1'b0;

		// bus handshake: one wait cycle, then one acknowledged cycle
		d.waitreq = 1'b1;
		if (accept) begin
			d.waitreq = 1'b0;
		end
		if (rd_accept) begin
			d.rdata = {24'h000000, rmux};
		end

		// read side effects happen where the data is captured
		if (rd_accept && hit(av_req.address, IDX_RESULT_LOW)) begin
			d.low_pend = 1'b1;
		end
		if (rd_accept && hit(av_req.address, IDX_RESULT_HIGH)) begin
			d.done     = 1'b0;
			d.low_pend = 1'b0;
		end

		// conversion engine; a set of done here wins over the read clear
		if (q.busy) begin
			if (q.cnt == 11'd1) begin
				if (!q.low_pend) begin
					d.result = analog_value;
					d.done   = 1'b1;
					d.irq    = 1'b1;
				end
				if (q.mode == MODE_REPEAT) begin
					d.cnt = conv_cycles(q.ctime);
				end else begin
					d.busy = 1'b0;
				end
			end else begin
				d.cnt = q.cnt - 11'd1;
			end
		end

		// start: one cycle after the write, so latency stays far under the limit
		if (q.start && !q.busy && mode_runs) begin
			d.start = 1'b0;
			d.busy  = 1'b1;
			d.cnt   = conv_cycles(q.ctime);
			if (q.mode == MODE_SINGLE) begin
				d.done = 1'b0;
			end
		end

		// register writes take effect on the acknowledged edge only
		if (wr_commit && hit(av_req.address, IDX_CONTROL)) begin
			d.start = wd[CTL_START_BIT];
			d.mode  = wd[CTL_MODE_LSB +: 2];
			d.gate  = wd[CTL_GATE_BIT];
			d.chan  = wd[CTL_CHAN_LSB +: 4];
			if (wd[CTL_MODE_LSB +: 2] == MODE_STOP) begin
				d.busy     = 1'b0;
				d.done     = 1'b0;
				d.irq      = 1'b0;
				d.result   = RESULT_RESET;
				d.low_pend = 1'b0;
			end
		end
		if (wr_commit && hit(av_req.address, IDX_STATUS)) begin
			d.ctime = wd[STS_TIME_LSB +: 3];                          // bit 3 ignored
		end

		// power mode entry overrides start, mode, gate and the engine, including a completion
		if (low_power_entry) begin
			d.start    = 1'b0;
			d.mode     = MODE_STOP;
			d.gate     = 1'b0;
			d.busy     = 1'b0;
			d.done     = 1'b0;
			d.irq      = 1'b0;
			d.result   = RESULT_RESET;
			d.low_pend = 1'b0;
		end

		d.chan_en = chan_onehot(d.gate, d.chan);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------

	// synchronous reset; every field takes a constant
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			q.waitreq  <= 1'b1;
			q.rdata    <= 32'h00000000;
			q.start    <= CONTROL_RESET[CTL_START_BIT];
			q.mode     <= CONTROL_RESET[CTL_MODE_LSB +: 2];
			q.gate     <= CONTROL_RESET[CTL_GATE_BIT];
			q.chan     <= CONTROL_RESET[CTL_CHAN_LSB +: 4];
			q.ctime    <= TIME_RESET;
			q.busy     <= 1'b0;
			q.done     <= 1'b0;
			q.irq      <= 1'b0;
			q.low_pend <= 1'b0;
			q.cnt      <= 11'h000;
			q.result   <= RESULT_RESET;
			q.chan_en  <= 8'h00;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// outputs, all straight from state flops
	// ------------------------------------------------------------
	assign avs_waitrequest           = q.waitreq;
	assign avs_readdata              = q.rdata;
	assign channel_enable            = q.chan_en;
	assign sample_active             = q.busy;
	assign conversion_done_interrupt = q.irq;

endmodule

// [pkg/sac_pkg.sv]
// shared constants and carrier types for the converter control block
package sac_pkg;

	// ------------------------------------------------------------
	// register map: printed indices, byte address is four times index
	// ------------------------------------------------------------
	localparam int          ADDR_W           = 10;
	localparam logic [7:0]  IDX_CONTROL      = 8'h34;
	localparam logic [7:0]  IDX_STATUS       = 8'h35;
	localparam logic [7:0]  IDX_RESULT_LOW   = 8'h36;
	localparam logic [7:0]  IDX_RESULT_HIGH  = 8'h37;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int          CTL_START_BIT    = 7;
	localparam int          CTL_MODE_LSB     = 5;
	localparam int          CTL_GATE_BIT     = 4;
	localparam int          CTL_CHAN_LSB     = 0;
	localparam int          STS_DONE_BIT     = 7;
	localparam int          STS_BUSY_BIT     = 6;
	localparam int          STS_TIME_LSB     = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  CONTROL_RESET    = 8'h00;
	localparam logic [2:0]  TIME_RESET       = 3'h0;
	localparam logic [9:0]  RESULT_RESET     = 10'h000;

	// ------------------------------------------------------------
	// operating modes
	// ------------------------------------------------------------
	localparam logic [1:0]  MODE_STOP        = 2'h0;
	localparam logic [1:0]  MODE_SINGLE      = 2'h1;
	localparam logic [1:0]  MODE_RESERVED    = 2'h2;
	localparam logic [1:0]  MODE_REPEAT      = 2'h3;

	// ------------------------------------------------------------
	// conversion lengths in high-frequency clock periods (clk_sys)
	// ------------------------------------------------------------
	localparam int          CNT_W            = 11;
	localparam logic [10:0] CONV_CYC_0       = 11'd39;
	localparam logic [10:0] CONV_CYC_1       = 11'd78;
	localparam logic [10:0] CONV_CYC_2       = 11'd156;
	localparam logic [10:0] CONV_CYC_3       = 11'd312;
	localparam logic [10:0] CONV_CYC_4       = 11'd624;
	localparam logic [10:0] CONV_CYC_5       = 11'd1248;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic              read;
		logic              write;
		logic [31:0]       writedata;
		logic [3:0]        byteenable;
	} sac_av_req_t;

	typedef struct packed {
		logic              waitreq;
		logic [31:0]       rdata;
		logic              start;
		logic [1:0]        mode;
		logic              gate;
		logic [3:0]        chan;
		logic [2:0]        ctime;
		logic              busy;
		logic              done;
		logic              irq;
		logic              low_pend;
		logic [CNT_W-1:0]  cnt;
		logic [9:0]        result;
		logic [7:0]        chan_en;
	} sac_state_t;

endpackage

// [testbench/sac_core_props.sv]
// assertion checker for the converter control block
`timescale 1ns/1ps
module sac_core_props
	import sac_pkg::*;
(
	input wire logic                 clk_sys,
	input wire logic                 sys_rst,
	input wire sac_pkg::sac_av_req_t av_req,
	input wire logic                 avs_waitrequest,
	input wire logic [31:0]          avs_readdata,
	input wire logic                 low_power_entry,
	input wire logic [9:0]           analog_value,
	input wire logic [7:0]           channel_enable,
	input wire logic                 sample_active,
	input wire logic                 conversion_done_interrupt
);
	logic [11:0] run_q;
	logic [11:0] run_d;
	logic        rd_ack;
	// ------------------------------------------------------------
	// conversion length counter, saturating so a hang still fails
	// ------------------------------------------------------------
	always_comb begin
		run_d = 12'h000;
		if (sample_active)
			run_d = conversion_done_interrupt ? 12'h001 : run_q + {11'h0, run_q != 12'hfff};
	end
	always_ff @(posedge clk_sys) begin
		run_q <= sys_rst ? 12'h000 : run_d;
	end
	// read answer cycle, request still held
	assign rd_ack = !avs_waitrequest && av_req.read;
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_WAIT_ONE: assert property ((av_req.read || av_req.write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait");
	AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_CHAN_ONEHOT: assert property ($onehot0(channel_enable))
		else $error("more than one input connected");
	AST_IRQ_PULSE: assert property (conversion_done_interrupt |=> !conversion_done_interrupt)
		else $error("interrupt pulse too long");
	AST_IRQ_BUSY: assert property (conversion_done_interrupt |-> $past(sample_active))
		else $error("interrupt without a running conversion");
	AST_CONV_MIN: assert property (conversion_done_interrupt |-> run_q >= 12'd39)
		else $error("conversion shorter than shortest time");
	AST_CONV_MAX: assert property (run_q <= 12'd1376)
		else $error("conversion longer than longest time");
	AST_POWER: assert property (low_power_entry |=> !sample_active && !conversion_done_interrupt)
		else $error("power entry left converter running");
	AST_STATUS_ZERO: assert property (rd_ack && av_req.address == {IDX_STATUS, 2'b00}
		|-> avs_readdata[5:3] == 3'h0) else $error("status bits 5..3 not zero");
	AST_HIGH_ZERO: assert property (rd_ack && av_req.address == {IDX_RESULT_HIGH, 2'b00}
		|-> avs_readdata[7:2] == 6'h00) else $error("upper result bits not zero");
	AST_START_CLEAR: assert property (rd_ack && av_req.address == {IDX_CONTROL, 2'b00}
		&& $past(sample_active) |-> !avs_readdata[CTL_START_BIT]) else $error("start bit stuck");
endmodule

// [testbench/sac_core_tb.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sac_core_tb;
	import sac_pkg::*;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	sac_av_req_t av_req = {10'h000, 1'b0, 1'b0, 32'h0, 4'h1};
	logic        low_power_entry = 1'b0;
	logic [9:0]  analog_value = 10'h000;
	logic        avs_waitrequest;
	logic [31:0] avs_readdata;
	logic [7:0]  channel_enable;
	logic        sample_active;
	logic        conversion_done_interrupt;
	logic [31:0] rd;
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc = 0;
	int          irq_cnt = 0;
	int          irq_at = 0;
	// 40 MHz clock
	always #12.5 clk_sys = ~clk_sys;
	sac_core i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .av_req(av_req),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.low_power_entry(low_power_entry), .analog_value(analog_value),
		.channel_enable(channel_enable), .sample_active(sample_active),
		.conversion_done_interrupt(conversion_done_interrupt));
	// interrupt log, so no one-cycle pulse is missed while the bus is busy
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (conversion_done_interrupt === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
			irq_at  <= cyc;
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// one transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		@(posedge clk_sys);
		av_req.address   <= {idx, 2'b00};
		av_req.read      <= ~wr;
		av_req.write     <= wr;
		av_req.writedata <= {24'h0, wd};
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			err_total++;
			give_verdict();
		end
		rd = avs_readdata;
		av_req.read  <= 1'b0;
		av_req.write <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp, input string nm);
		bus(1'b0, idx, 8'h00);
		check(nm, rd, {24'h0, exp});
	endtask
	task automatic wait_irq(input int target);
		for (int n = 0; n < 3000 && irq_cnt < target; n++) @(posedge clk_sys);
		if (irq_cnt < target) begin
			err_total++;
			give_verdict();
		end
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic s_reset();
		rchk(IDX_CONTROL, 8'h00, "ctrl");
		rchk(IDX_STATUS, 8'h00, "status");
		rchk(IDX_RESULT_LOW, 8'h00, "low");
		rchk(IDX_RESULT_HIGH, 8'h00, "high");
		rchk(8'h00, 8'h00, "unmapped");
	endtask
	// every channel, a reserved code, then gate off
	task automatic s_gate();
		for (int c = 0; c < 10; c++) begin
			bus(1'b1, IDX_CONTROL, (c == 9) ? 8'h03 : 8'h10 | c[7:0]);
			repeat (2) @(posedge clk_sys);
			check("chan_en", {24'h0, channel_enable}, (c < 8) ? 32'h1 << c : 32'h0);
		end
		// reserved mode with start set must not run
		bus(1'b1, IDX_CONTROL, 8'hd0);
		repeat (2) @(posedge clk_sys);
		check("rsv busy", {31'h0, sample_active}, 32'h0);
		rchk(IDX_STATUS, 8'h00, "rsv status");
	endtask
	// single conversion at time codes 0 to 5; odd codes leave done set
	task automatic s_times();
		int d;
		int k;
		logic [9:0] v;
		for (int t = 0; t < 6; t++) begin
			v = 10'h2a5 + 10'(t * 97);
			analog_value <= v;
			k = irq_cnt;
			bus(1'b1, IDX_STATUS, 8'(t));
			bus(1'b1, IDX_CONTROL, 8'hb3);
			d = cyc;
			rchk(IDX_STATUS, 8'h40 | 8'(t), "status run");
			rchk(IDX_CONTROL, 8'h33, "ctrl run");
			wait_irq(k + 1);
			d = irq_at - d - 2;
			check("conv time", 32'(d >= (39 << t) && d <= (39 << t) + (t < 2 ? 10 : t < 4 ? 32 : 128)),
				32'h1);
			check("busy end", {31'h0, sample_active}, 32'h0);
			rchk(IDX_STATUS, 8'h80 | 8'(t), "status done");
			if (t % 2 == 0) begin
				rchk(IDX_RESULT_LOW, v[7:0], "low");
				rchk(IDX_RESULT_HIGH, {6'h0, v[9:8]}, "high");
				rchk(IDX_STATUS, 8'(t), "status read");
			end
		end
	endtask
	// repeat mode: completion between low and high reads, then forced stop
	task automatic s_repeat();
		int k;
		bus(1'b1, IDX_STATUS, 8'h00);
		analog_value <= 10'h155;
		k = irq_cnt;
		bus(1'b1, IDX_CONTROL, 8'hf6);
		wait_irq(k + 1);
		rchk(IDX_RESULT_LOW, 8'h55, "rep low");
		analog_value <= 10'h2aa;
		repeat (60) @(posedge clk_sys);
		check("rep drop", 32'(irq_cnt), 32'(k + 1));
		rchk(IDX_RESULT_HIGH, 8'h01, "rep old");
		wait_irq(k + 2);
		check("rep busy", {31'h0, sample_active}, 32'h1);
		rchk(IDX_RESULT_LOW, 8'haa, "rep new");
		rchk(IDX_RESULT_HIGH, 8'h02, "rep new hi");
		bus(1'b1, IDX_CONTROL, 8'h16);
		k = irq_cnt;
		repeat (100) @(posedge clk_sys);
		check("stop irq", 32'(irq_cnt), 32'(k));
		rchk(IDX_STATUS, 8'h00, "stop status");
		rchk(IDX_RESULT_LOW, 8'h00, "stop low");
		rchk(IDX_RESULT_HIGH, 8'h00, "stop high");
	endtask
	// power mode entry in mid conversion with an old result held
	task automatic s_power();
		int k;
		k = irq_cnt;
		bus(1'b1, IDX_CONTROL, 8'hb5);
		wait_irq(k + 1);
		bus(1'b1, IDX_CONTROL, 8'hb5);
		repeat (10) @(posedge clk_sys);
		low_power_entry <= 1'b1;
		@(posedge clk_sys);
		low_power_entry <= 1'b0;
		repeat (60) @(posedge clk_sys);
		check("pwr irq", 32'(irq_cnt), 32'(k + 1));
		check("pwr chan", {24'h0, channel_enable}, 32'h0);
		rchk(IDX_CONTROL, 8'h05, "pwr ctrl");
		rchk(IDX_STATUS, 8'h00, "pwr status");
		rchk(IDX_RESULT_LOW, 8'h00, "pwr low");
		rchk(IDX_RESULT_HIGH, 8'h00, "pwr high");
	endtask
	initial begin
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		s_reset();
		s_gate();
		s_times();
		s_repeat();
		s_power();
		give_verdict();
	end
endmodule
bind sac_core sac_core_props i_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .av_req(av_req),
	.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
	.low_power_entry(low_power_entry), .analog_value(analog_value),
	.channel_enable(channel_enable), .sample_active(sample_active),
	.conversion_done_interrupt(conversion_done_interrupt));
